//--- src/rtc_alarm_wakeup.sv
/*
 Real-time clock: 32-bit seconds counter with alarm match and a 16-bit
 1 ms one-shot wake-up timer, both ticked from a 32.768 kHz oscillator.
 Assumes the oscillator level is synchronous to i_clk and no faster than it.
*/
`timescale 1ns/1ns
`default_nettype none
module rtc_alarm_wakeup #(
	parameter int SEC_DIVIDE = rtc_pkg::SEC_DIV,
	parameter int MS_DIVIDE = rtc_pkg::MS_DIV
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	input wire logic i_osc,
	input wire rtc_pkg::ctrl_t i_ctrl,
	input wire logic i_sec_load,
	input wire logic [rtc_pkg::SEC_W-1:0] i_sec_value,
	input wire logic [rtc_pkg::SEC_W-1:0] i_match,
	input wire logic i_wake_load,
	input wire logic [rtc_pkg::WAKE_W-1:0] i_wake_value,
	input wire rtc_pkg::irq_t i_irq_clr,
	input wire logic i_low_power,
	output logic [rtc_pkg::SEC_W-1:0] o_seconds,
	output logic [rtc_pkg::WAKE_W-1:0] o_wake_count,
	output logic o_wake_running,
	output rtc_pkg::irq_t o_irq,
	output logic o_wakeup,
	output logic o_sysclk_osc,
	output logic o_clock_output_pin
);
	import rtc_pkg::*;

	if (SEC_DIVIDE < 2 || MS_DIVIDE < 2 || SEC_DIVIDE < MS_DIVIDE) begin : g_div_check
		$error("Divider values unsupported");
	end

	localparam int DW = $clog2(SEC_DIVIDE + 1);
	localparam logic [DW-1:0] SEC_LAST = DW'(SEC_DIVIDE - 1);
	localparam logic [DW-1:0] MS_LAST = DW'(MS_DIVIDE - 1);
	localparam logic [DW-1:0] DIV_ZERO = '0;

	logic osc_r, osc_nxt;
	logic osc_rise;
	logic [DW-1:0] sdiv_r, sdiv_nxt, mdiv_r, mdiv_nxt;
	logic sec_tick, ms_tick;
	logic [SEC_W-1:0] sec_r, sec_nxt;
	logic [WAKE_W-1:0] wake_r, wake_nxt;
	wake_state_t wst_r, wst_nxt;
	irq_t irq_r, irq_nxt;
	logic wakeup_r, wakeup_nxt;
	logic run_r, run_nxt;
	logic sclk_r, sclk_nxt, cko_r, cko_nxt;
	logic alarm_hit, wake_hit;

	// Prescalers count oscillator rising edges
	always_comb begin
		osc_nxt = i_osc;
		osc_rise = i_osc && !osc_r;
		sec_tick = osc_rise && (sdiv_r == SEC_LAST);
		ms_tick = osc_rise && (mdiv_r == MS_LAST);
		sdiv_nxt = sdiv_r;
		mdiv_nxt = mdiv_r;
		if (osc_rise) begin
			sdiv_nxt = sec_tick ? DIV_ZERO : sdiv_r + DW'(1);
			// Millisecond divider gated off with the wake timer to save power
			if (wst_r == WAKE_RUN && i_ctrl.wake_timer_en) begin
				mdiv_nxt = ms_tick ? DIV_ZERO : mdiv_r + DW'(1);
			end
		end
		if (wst_r != WAKE_RUN || !i_ctrl.wake_timer_en)
			mdiv_nxt = DIV_ZERO;
	end

	// Seconds counter; wrap is natural modulo arithmetic
	always_comb begin
		sec_nxt = sec_r;
		if (i_sec_load)
			sec_nxt = i_sec_value;
		else if (sec_tick)
			sec_nxt = sec_r + SEC_W'(1);
		alarm_hit = sec_tick && !i_sec_load && (sec_nxt == i_match);
	end

	// One-shot wake-up timer
	always_comb begin
		wake_nxt = wake_r;
		wst_nxt = wst_r;
		wake_hit = 1'b0;
		case (wst_r)
			WAKE_IDLE: begin
				if (i_wake_load && i_ctrl.wake_timer_en && i_wake_value != WAKE_ZERO) begin
					wake_nxt = i_wake_value;
					wst_nxt = WAKE_RUN;
				end
			end
			WAKE_RUN: begin
				if (!i_ctrl.wake_timer_en) begin
					wst_nxt = WAKE_IDLE;
				end else if (i_wake_load) begin
					wake_nxt = i_wake_value;
					if (i_wake_value == WAKE_ZERO)
						wst_nxt = WAKE_IDLE;
				end else if (ms_tick) begin
					wake_nxt = wake_r - WAKE_W'(1);
					if (wake_r == WAKE_W'(1)) begin
						wake_hit = 1'b1;
						wst_nxt = WAKE_IDLE;
					end
				end
			end
			default: wst_nxt = WAKE_IDLE;
		endcase
		run_nxt = (wst_nxt == WAKE_RUN);
	end

	// Sticky flags: a set in the clear cycle wins
	always_comb begin
		irq_nxt.alarm = alarm_hit || (irq_r.alarm && !i_irq_clr.alarm);
		irq_nxt.wake = wake_hit || (irq_r.wake && !i_irq_clr.wake);
		wakeup_nxt = i_low_power && ((irq_nxt.alarm && i_ctrl.alarm_wake_en) || irq_nxt.wake);
		// Registered copy of the oscillator; a gated clock would need a cell
		sclk_nxt = i_ctrl.sysclk_sel_osc && i_osc;
		cko_nxt = i_ctrl.clock_output_pin_sel_osc && i_osc;
	end

	// Prescaler state
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			osc_r <= 1'b0;
			sdiv_r <= DIV_ZERO;
			mdiv_r <= DIV_ZERO;
		end else if (i_ce) begin
			osc_r <= osc_nxt;
			sdiv_r <= sdiv_nxt;
			mdiv_r <= mdiv_nxt;
		end
	end

	// Seconds state
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sec_r <= SEC_RST;
		end else if (i_ce) begin
			sec_r <= sec_nxt;
		end
	end

	// Wake-up timer state
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			wake_r <= WAKE_ZERO;
			wst_r <= WAKE_IDLE;
			run_r <= 1'b0;
		end else if (i_ce) begin
			wake_r <= wake_nxt;
			wst_r <= wst_nxt;
			run_r <= run_nxt;
		end
	end

	// Flags and output copies
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			irq_r <= '0;
			wakeup_r <= 1'b0;
			sclk_r <= 1'b0;
			cko_r <= 1'b0;
		end else if (i_ce) begin
			irq_r <= irq_nxt;
			wakeup_r <= wakeup_nxt;
			sclk_r <= sclk_nxt;
			cko_r <= cko_nxt;
		end
	end

	assign o_seconds = sec_r;
	assign o_wake_count = wake_r;
	assign o_wake_running = run_r;
	assign o_irq = irq_r;
	assign o_wakeup = wakeup_r;
	assign o_sysclk_osc = sclk_r;
	assign o_clock_output_pin = cko_r;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	sec_advance_a: assert property (i_ce && sec_tick && !i_sec_load
		|=> sec_r == $past(sec_r) + SEC_W'(1))
		else $error("seconds did not advance");

	sec_hold_a: assert property (i_ce && !sec_tick && !i_sec_load
		|=> $stable(sec_r))
		else $error("seconds moved without tick");

	sec_load_a: assert property (i_ce && i_sec_load
		|=> sec_r == $past(i_sec_value))
		else $error("seconds load lost");

	sec_wrap_a: assert property (i_ce && sec_tick && !i_sec_load && sec_r == '1
		|=> sec_r == '0)
		else $error("seconds did not wrap to zero");

	freeze_a: assert property (!i_ce
		|=> $stable(sec_r) && $stable(wake_r) && $stable(irq_r))
		else $error("state moved with enable low");

	alarm_set_a: assert property (i_ce && alarm_hit
		|=> irq_r.alarm)
		else $error("alarm not raised on match");

	alarm_cause_a: assert property (i_ce && !irq_r.alarm ##1 irq_r.alarm
		|-> $past(sec_tick) && !$past(i_sec_load) && sec_r == $past(i_match))
		else $error("alarm without cause");

	alarm_sticky_a: assert property (i_ce && irq_r.alarm && !i_irq_clr.alarm
		|=> irq_r.alarm)
		else $error("alarm flag lost");

	alarm_wake_a: assert property (i_ce && i_low_power && irq_nxt.alarm && i_ctrl.alarm_wake_en
		|=> o_wakeup)
		else $error("no wake-up on alarm");

	no_wake_a: assert property (i_ce && !i_low_power
		|=> !o_wakeup)
		else $error("wake-up outside low power");

	wake_load_a: assert property (i_ce && !o_wake_running && i_wake_load
		&& i_ctrl.wake_timer_en && i_wake_value != WAKE_ZERO
		|=> o_wake_running && wake_r == $past(i_wake_value))
		else $error("wake load did not start timer");

	wake_zero_a: assert property (i_ce && i_wake_load && i_wake_value == WAKE_ZERO
		|=> !o_wake_running)
		else $error("zero load left timer running");

	wake_step_a: assert property (i_ce && o_wake_running && i_ctrl.wake_timer_en
		&& ms_tick && !i_wake_load |=> wake_r == $past(wake_r) - WAKE_W'(1))
		else $error("wake timer did not step down");

	wake_stop_a: assert property (i_ce && wst_r == WAKE_RUN && ms_tick && !i_wake_load
		&& i_ctrl.wake_timer_en && wake_r == WAKE_W'(1)
		|=> !o_wake_running && irq_r.wake && wake_r == WAKE_ZERO)
		else $error("wake timer did not stop at zero");

	wake_hold_a: assert property (!o_wake_running && !i_wake_load
		|=> $stable(wake_r))
		else $error("idle wake counter moved");

	wake_off_a: assert property (i_ce && !i_ctrl.wake_timer_en
		|=> !o_wake_running && mdiv_r == DIV_ZERO)
		else $error("disabled wake timer running");

	sticky_a: assert property (i_ce && irq_r.wake && !i_irq_clr.wake
		|=> irq_r.wake)
		else $error("wake flag lost");

	wake_clear_a: assert property (i_ce && i_irq_clr.wake && !wake_hit
		|=> !irq_r.wake)
		else $error("wake flag not cleared");

	wake_only_a: assert property (i_ce && !irq_r.wake && !wake_hit
		|=> !irq_r.wake)
		else $error("wake flag set without expiry");

	sec_div_a: assert property (sec_tick
		|-> osc_rise && sdiv_r == SEC_LAST)
		else $error("seconds tick off divider");

	ms_div_a: assert property (ms_tick
		|-> osc_rise && mdiv_r == MS_LAST)
		else $error("millisecond tick off divider");

	wake_up_a: assert property (i_ce && i_low_power && irq_nxt.wake
		|=> o_wakeup)
		else $error("no wake-up on expiry");

	cko_a: assert property (i_ce && !i_ctrl.clock_output_pin_sel_osc
		|=> !o_clock_output_pin)
		else $error("clock out not gated");

	sclk_a: assert property (i_ce && !i_ctrl.sysclk_sel_osc
		|=> !o_sysclk_osc)
		else $error("system clock copy not gated");

	alarm_c: cover property (irq_r.alarm && !$past(irq_r.alarm));
	wake_c: cover property (irq_r.wake && !$past(irq_r.wake));
	reload_c: cover property (o_wake_running && i_wake_load);
	wakeup_c: cover property (o_wakeup);
	wrap_c: cover property (sec_tick && sec_r == '1);
endmodule : rtc_alarm_wakeup
`default_nettype wire

//--- src/rtc_pkg.sv
/*
 Package for the real-time clock with alarm and wake-up timer.
 Assumes a 100 MHz system clock and a 32.768 kHz oscillator level sampled on it.
*/
package rtc_pkg;
	localparam int SEC_W = 32;
	localparam int WAKE_W = 16;
	// 32768 Hz / 1 Hz and 32768 Hz / 1 kHz (integer; 32 osc cycles, 32.768 truncated)
	localparam int OSC_HZ = 32768;
	localparam int SEC_DIV = OSC_HZ / 1;
	localparam int MS_DIV = OSC_HZ / 1000;
	localparam logic [SEC_W-1:0] SEC_RST = 32'h0000_0000;
	localparam logic [SEC_W-1:0] MATCH_RST = 32'hFFFF_FFFF;
	localparam logic [WAKE_W-1:0] WAKE_ZERO = 16'h0000;

	typedef struct packed {
		logic alarm;
		logic wake;
	} irq_t;

	typedef struct packed {
		logic alarm_wake_en;
		logic wake_timer_en;
		logic clock_output_pin_sel_osc;
		logic sysclk_sel_osc;
	} ctrl_t;

	typedef enum logic [0:0] {WAKE_IDLE, WAKE_RUN} wake_state_t;
endpackage : rtc_pkg

//--- verification/rtc_alarm_wakeup_tb.sv
/*
 Self-checking bench for rtc_alarm_wakeup, dividers shortened to 8 and 2.
 Assumes the oscillator level is made here, synchronous to i_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module rtc_alarm_wakeup_tb;
	import rtc_pkg::*;
	logic i_clk, i_sys_rst, i_ce, i_osc, i_sec_load, i_wake_load, i_low_power;
	ctrl_t i_ctrl;
	irq_t i_irq_clr, o_irq;
	logic [SEC_W-1:0] i_sec_value, i_match, o_seconds, snap;
	logic [WAKE_W-1:0] i_wake_value, o_wake_count;
	logic o_wake_running, o_wakeup, o_sysclk_osc, o_clock_output_pin, alarm_q, wake_q;
	logic [SEC_W-1:0] exp_sec[$];
	logic [WAKE_W-1:0] exp_wake[$];
	int error_cnt = 0, n_tests = 0, k, rises, lo;
	rtc_alarm_wakeup #(.SEC_DIVIDE(8), .MS_DIVIDE(2)) u_dut (.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_ce(i_ce), .i_osc(i_osc), .i_ctrl(i_ctrl), .i_sec_load(i_sec_load),
		.i_sec_value(i_sec_value), .i_match(i_match), .i_wake_load(i_wake_load),
		.i_wake_value(i_wake_value), .i_irq_clr(i_irq_clr), .i_low_power(i_low_power),
		.o_seconds(o_seconds), .o_wake_count(o_wake_count), .o_wake_running(o_wake_running),
		.o_irq(o_irq), .o_wakeup(o_wakeup), .o_sysclk_osc(o_sysclk_osc),
		.o_clock_output_pin(o_clock_output_pin));
	task automatic check(input string what, input logic [SEC_W-1:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %0h seen %0h", what, exp, seen);
		end
	endtask : check
	task automatic print_verdict;
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : tick
	initial begin
		i_clk = 0;
		forever #5 i_clk = ~i_clk;
	end
	// Slow level, four system cycles a period
	initial begin
		i_osc = 0;
		forever begin
			repeat (2) @(posedge i_clk);
			#1 i_osc = ~i_osc;
		end
	end
	initial begin
		#200000;
		error_cnt++;
		print_verdict();
	end
	// Results are judged only when a flag rises
	// Mid-cycle sampling keeps clear of the launching edge
	always @(negedge i_clk) begin
		alarm_q <= o_irq.alarm;
		wake_q <= o_irq.wake;
		if (o_irq.alarm && !alarm_q) check("alarm sec", o_seconds, exp_sec.pop_front());
		if (o_irq.wake && !wake_q) begin
			check("wake cnt", o_wake_count, exp_wake.pop_front());
			check("wake stop", o_wake_running, 1'b0);
		end
	end
	initial begin
		void'($urandom(55));
		{i_ce, i_sec_load, i_wake_load, i_low_power} = 4'h8;
		i_ctrl = '0;
		i_irq_clr = '0;
		i_sec_value = '0;
		i_match = 32'hFFFF_FFFF;
		i_wake_value = '0;
		i_sys_rst = 1;
		tick(3);
		i_sys_rst = 0;
		check("sec rst", o_seconds, SEC_RST);
		check("irq rst", o_irq, 2'h0);
		// Wrap passes zero without alarm, match fires at one
		i_match = 32'h0000_0001;
		i_sec_value = 32'hFFFF_FFFE;
		i_sec_load = 1;
		exp_sec.push_back(32'h0000_0001);
		tick(1);
		i_sec_load = 0;
		check("sec load", o_seconds, 32'hFFFF_FFFE);
		for (k = 0; k < 400 && !o_irq.alarm; k++) tick(1);
		check("alarm", o_irq.alarm, 1'b1);
		i_ctrl.wake_timer_en = 1;
		i_low_power = 1;
		for (int j = 0; j < 3; j++) begin
			i_wake_value = 16'(1 + $urandom % 4);
			i_wake_load = 1;
			exp_wake.push_back(WAKE_ZERO);
			tick(1);
			i_wake_load = 0;
			check("running", o_wake_running, 1'b1);
			check("no wake", o_wakeup, 1'b0);
			for (k = 0; k < 400 && !o_irq.wake; k++) tick(1);
			// Two osc rises per ms, four cycles each; first step may come early
			lo = (int'(i_wake_value) - 1) * 8 + 5;
			check("wake time", 32'(k >= lo && k <= lo + 3), 32'h0000_0001);
			tick(1);
			check("wakeup", o_wakeup, 1'b1);
			i_irq_clr.wake = 1;
			tick(1);
			i_irq_clr = '0;
			check("wake clr", o_irq.wake, 1'b0);
			check("alarm kept", o_irq.alarm, 1'b1);
		end
		for (int j = 0; j < 2; j++) begin
			i_ctrl.wake_timer_en = 1'(j);
			i_wake_value = j ? 16'h0000 : 16'h0005;
			i_wake_load = 1;
			tick(1);
			i_wake_load = 0;
			check("refused", o_wake_running, 1'b0);
		end
		i_ctrl.alarm_wake_en = 1;
		tick(2);
		check("alarm wake", o_wakeup, 1'b1);
		i_irq_clr.alarm = 1;
		tick(1);
		i_irq_clr = '0;
		tick(1);
		check("wake drop", o_wakeup, 1'b0);
		// Freeze spans whole osc periods so no rise is lost or doubled
		snap = o_seconds;
		i_ce = 0;
		tick(40);
		check("frozen", o_seconds, snap);
		i_ce = 1;
		tick(32);
		check("sec rate", o_seconds - snap, 32'h0000_0001);
		for (int s = 1; s >= 0; s--) begin
			i_ctrl.clock_output_pin_sel_osc = 1'(s);
			i_ctrl.sysclk_sel_osc = 1'(s);
			tick(4);
			rises = 0;
			for (k = 0; k < 16; k++) begin
				tick(1);
				rises += int'(o_clock_output_pin) + int'(o_sysclk_osc);
			end
			check("osc copies", 32'(rises), 32'(16 * s));
		end
		i_sys_rst = 1;
		tick(3);
		i_sys_rst = 0;
		check("rerun sec", o_seconds, SEC_RST);
		check("rerun run", o_wake_running, 1'b0);
		check("rerun irq", o_irq, 2'h0);
		check("pending", 32'(exp_sec.size() + exp_wake.size()), 32'h0000_0000);
		print_verdict();
	end
endmodule : rtc_alarm_wakeup_tb
`default_nettype wire
